// *** hdl/exec_pkg.sv ***
package exec_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SP = 8'h04;
  localparam logic [7:0] OFS_IP = 8'h08;
  localparam logic [7:0] OFS_CS = 8'h0C;
  localparam logic [7:0] OFS_IMM = 8'h10;
  localparam logic [7:0] OFS_DEST = 8'h14;
  localparam logic [7:0] OFS_CL = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_HAS_IMM = 3;
  localparam int CTRL_WORD = 4;
  localparam int CTRL_CNT_REG = 5;
  localparam int CTRL_DEST_MEM = 6;
  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  // Flag word positions
  localparam int FLAG_CF = 0;
  localparam int FLAG_OF = 11;
  // Operation codes
  localparam logic [1:0] OP_RET_NEAR = 2'h0;
  localparam logic [1:0] OP_RET_FAR = 2'h1;
  localparam logic [1:0] OP_ROL = 2'h2;
  // Stack step and bus responses
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_POP_IP = 3'b001,
    ST_POP_CS = 3'b010,
    ST_ADJ = 3'b011,
    ST_ROT_RD = 3'b100,
    ST_ROT_STEP = 3'b101,
    ST_ROT_WR = 3'b110
  } exec_state_t;
endpackage

// *** hdl/return_and_rotate_left_exec.sv ***
module return_and_rotate_left_exec
  import exec_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mem_req,
  output logic mem_we,
  output logic mem_word,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);

  typedef struct packed {
    exec_state_t state;
    logic awready;
    logic wready;
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] op;
    logic has_imm;
    logic word;
    logic cnt_reg;
    logic dest_mem;
    logic busy;
    logic done;
    logic [15:0] stack_pointer_reg;
    logic [15:0] instr_pointer_reg;
    logic [15:0] cs;
    logic [7:0] imm;
    logic [15:0] dest;
    logic [7:0] count_low_reg;
    logic [15:0] flags;
    logic [7:0] cnt;
    logic cnt_one;
    logic mreq;
    logic mwe;
    logic [15:0] maddr;
    logic [15:0] mwdata;
    logic mword;
  } exec_st_t;

  exec_st_t s_ff;
  exec_st_t nxt_s;
  // Merge a write into a 16-bit register under byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] b);
    merge16 = {b[1] ? d[15:8] : old[15:8], b[0] ? d[7:0] : old[7:0]};
  endfunction
  // Decode a byte offset into a mapped register
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_CTRL) || (a == OFS_SP) || (a == OFS_IP) || (a == OFS_CS) || (a == OFS_IMM)
      || (a == OFS_DEST) || (a == OFS_CL) || (a == OFS_FLAGS) || (a == OFS_STATUS);
  endfunction
  // Top bit of the destination at the operand size
  function automatic logic top_bit(input logic [15:0] d, input logic w);
    top_bit = w ? d[15] : d[7];
  endfunction
  // One rotate-left step at the operand size; high byte kept for byte operands
  function automatic logic [15:0] rol1(input logic [15:0] d, input logic w);
    rol1 = w ? {d[14:0], d[15]} : {d[15:8], d[6:0], d[7]};
  endfunction
  logic [15:0] rot_val;
  logic rot_cf;
  assign rot_val = rol1(s_ff.dest, s_ff.word);
  assign rot_cf = top_bit(s_ff.dest, s_ff.word);

  // Next-state logic for bus slave and execution sequencer
  always_comb begin
    nxt_s = s_ff;
    // Write address and data taken in either order
    if (s_axi_awvalid && s_ff.awready) begin
      nxt_s.aw_ok = 1'b1;
      nxt_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_ff.wready) begin
      nxt_s.w_ok = 1'b1;
      nxt_s.w_data = s_axi_wdata;
      nxt_s.w_strb = s_axi_wstrb;
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_ok && s_ff.w_ok && !s_ff.bvalid) begin
      nxt_s.aw_ok = 1'b0;
      nxt_s.w_ok = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = is_mapped(s_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      // Writes while busy are dropped so operands stay steady
      if (!s_ff.busy) begin
        case (s_ff.aw_addr)
          OFS_CTRL: begin
            if (s_ff.w_strb[0]) begin
              nxt_s.op = s_ff.w_data[CTRL_OP_LO+1:CTRL_OP_LO];
              nxt_s.has_imm = s_ff.w_data[CTRL_HAS_IMM];
              nxt_s.word = s_ff.w_data[CTRL_WORD];
              nxt_s.cnt_reg = s_ff.w_data[CTRL_CNT_REG];
              nxt_s.dest_mem = s_ff.w_data[CTRL_DEST_MEM];
              if (s_ff.w_data[CTRL_START]) begin
                nxt_s.busy = 1'b1;
                nxt_s.done = 1'b0;
                nxt_s.mreq = 1'b0;
                nxt_s.mwe = 1'b0;
                case (s_ff.w_data[CTRL_OP_LO+1:CTRL_OP_LO])
                  OP_RET_NEAR, OP_RET_FAR: begin
                    nxt_s.state = ST_POP_IP;
                    nxt_s.mreq = 1'b1;
                    nxt_s.maddr = s_ff.stack_pointer_reg;
                  end
                  default: begin
                    nxt_s.cnt = s_ff.w_data[CTRL_CNT_REG] ? s_ff.count_low_reg : s_ff.imm;
                    nxt_s.cnt_one = (nxt_s.cnt == 8'h01);
                    if (nxt_s.cnt == 8'h00) begin
                      nxt_s.state = ST_IDLE;
                      nxt_s.busy = 1'b0;
                      nxt_s.done = 1'b1;
                    end else if (s_ff.w_data[CTRL_DEST_MEM]) begin
                      nxt_s.state = ST_ROT_RD;
                      nxt_s.mreq = 1'b1;
                      nxt_s.maddr = s_ff.dest;
                    end else begin
                      nxt_s.state = ST_ROT_STEP;
                    end
                  end
                endcase
              end
            end
          end
          OFS_SP: nxt_s.stack_pointer_reg = merge16(s_ff.stack_pointer_reg, s_ff.w_data, s_ff.w_strb);
          OFS_IP: nxt_s.instr_pointer_reg = merge16(s_ff.instr_pointer_reg, s_ff.w_data, s_ff.w_strb);
          OFS_CS: nxt_s.cs = merge16(s_ff.cs, s_ff.w_data, s_ff.w_strb);
          OFS_IMM: nxt_s.imm = s_ff.w_strb[0] ? s_ff.w_data[7:0] : s_ff.imm;
          OFS_DEST: nxt_s.dest = merge16(s_ff.dest, s_ff.w_data, s_ff.w_strb);
          OFS_CL: nxt_s.count_low_reg = s_ff.w_strb[0] ? s_ff.w_data[7:0] : s_ff.count_low_reg;
          OFS_FLAGS: nxt_s.flags = merge16(s_ff.flags, s_ff.w_data, s_ff.w_strb);
          default: ;
        endcase
      end
    end
    nxt_s.awready = !nxt_s.aw_ok && !nxt_s.bvalid;
    nxt_s.wready = !nxt_s.w_ok && !nxt_s.bvalid;

    // Read channel: one read under way, answered the cycle after it is taken
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_CTRL: nxt_s.rdata = {25'h0, s_ff.dest_mem, s_ff.cnt_reg, s_ff.word, s_ff.has_imm, s_ff.op, 1'b0};
        OFS_SP: nxt_s.rdata = {16'h0000, s_ff.stack_pointer_reg};
        OFS_IP: nxt_s.rdata = {16'h0000, s_ff.instr_pointer_reg};
        OFS_CS: nxt_s.rdata = {16'h0000, s_ff.cs};
        OFS_IMM: nxt_s.rdata = {24'h000000, s_ff.imm};
        OFS_DEST: nxt_s.rdata = {16'h0000, s_ff.dest};
        OFS_CL: nxt_s.rdata = {24'h000000, s_ff.count_low_reg};
        OFS_FLAGS: nxt_s.rdata = {16'h0000, s_ff.flags};
        OFS_STATUS: nxt_s.rdata = {30'h0, s_ff.done, s_ff.busy};
        default: nxt_s.rdata = 32'h00000000;
      endcase
    end
    nxt_s.arready = !nxt_s.rvalid;

    // Execution sequencer; no return state touches the flag word
    case (s_ff.state)
      ST_IDLE: ;
      ST_POP_IP: begin
        if (mem_ack) begin
          nxt_s.instr_pointer_reg = mem_rdata;
          nxt_s.stack_pointer_reg = s_ff.stack_pointer_reg + STACK_STEP;
          if (s_ff.op == OP_RET_FAR) begin
            nxt_s.state = ST_POP_CS;
            nxt_s.maddr = s_ff.stack_pointer_reg + STACK_STEP;
          end else begin
            nxt_s.state = ST_ADJ;
            nxt_s.mreq = 1'b0;
          end
        end
      end
      ST_POP_CS: begin
        if (mem_ack) begin
          nxt_s.cs = mem_rdata;
          nxt_s.stack_pointer_reg = s_ff.stack_pointer_reg + STACK_STEP;
          nxt_s.state = ST_ADJ;
          nxt_s.mreq = 1'b0;
        end
      end
      ST_ADJ: begin
        if (s_ff.has_imm) begin
          nxt_s.stack_pointer_reg = s_ff.stack_pointer_reg + {8'h00, s_ff.imm};
        end
        nxt_s.state = ST_IDLE;
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
      end
      ST_ROT_RD: begin
        if (mem_ack) begin
          nxt_s.dest = mem_rdata;
          nxt_s.mreq = 1'b0;
          nxt_s.state = ST_ROT_STEP;
        end
      end
      ST_ROT_STEP: begin
        if (s_ff.cnt != 8'h00) begin
          nxt_s.dest = rot_val;
          nxt_s.flags[FLAG_CF] = rot_cf;
          nxt_s.cnt = s_ff.cnt - 8'h01;
          if (s_ff.cnt_one) begin
            nxt_s.flags[FLAG_OF] = top_bit(rot_val, s_ff.word) ^ rot_cf;
          end
        end else if (s_ff.dest_mem) begin
          nxt_s.state = ST_ROT_WR;
          nxt_s.mreq = 1'b1;
          nxt_s.mwe = 1'b1;
          nxt_s.mwdata = s_ff.dest;
        end else begin
          nxt_s.state = ST_IDLE;
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
        end
      end
      ST_ROT_WR: begin
        if (mem_ack) begin
          nxt_s.mreq = 1'b0;
          nxt_s.mwe = 1'b0;
          nxt_s.state = ST_IDLE;
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
        end
      end
      default: begin
        nxt_s.state = ST_IDLE;
        nxt_s.busy = 1'b0;
      end
    endcase
    nxt_s.mword = (nxt_s.state == ST_POP_IP) || (nxt_s.state == ST_POP_CS) || nxt_s.word;
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
      s_ff.stack_pointer_reg <= RST_WORD;
      s_ff.imm <= RST_BYTE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;
  assign mem_req = s_ff.mreq;
  assign mem_we = s_ff.mwe;
  assign mem_word = s_ff.mword;
  assign mem_addr = s_ff.maddr;
  assign mem_wdata = s_ff.mwdata;

  a_ret_ip_pop: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_ff.state == ST_POP_IP && mem_ack) |=> (s_ff.instr_pointer_reg == $past(mem_rdata))
      && (s_ff.stack_pointer_reg == $past(s_ff.stack_pointer_reg) + STACK_STEP))
    else $error("instruction pointer pop wrong");
  a_far_cs_pop: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_ff.state == ST_POP_CS && mem_ack) |=> (s_ff.cs == $past(mem_rdata))
      && (s_ff.stack_pointer_reg == $past(s_ff.stack_pointer_reg) + STACK_STEP))
    else $error("code segment pop wrong");
  a_far_cs_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_ff.state == ST_POP_CS) |-> (mem_addr == s_ff.stack_pointer_reg) && mem_req && !mem_we)
    else $error("code segment read address wrong");
  a_ret_imm_add: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_ff.state == ST_ADJ && s_ff.has_imm) |=> (s_ff.stack_pointer_reg ==
      $past(s_ff.stack_pointer_reg) + {8'h00, $past(s_ff.imm)}))
    else $error("immediate not added to stack pointer");
  a_ret_resume: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_ff.state == ST_ADJ) |=> (s_ff.state == ST_IDLE) && s_ff.done && $stable(s_ff.instr_pointer_reg))
    else $error("return did not finish");
  a_ret_flags_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_ff.busy && s_ff.op != OP_ROL) |=> $stable(s_ff.flags))
    else $error("return changed flags");
  a_rot_step_val: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_ff.state == ST_ROT_STEP && s_ff.cnt != 8'h00 && s_ff.word) |=> (s_ff.dest ==
      {$past(s_ff.dest[14:0]), $past(s_ff.dest[15])}) && (s_ff.flags[FLAG_CF] == $past(s_ff.dest[15])))
    else $error("rotate step wrong");
  a_rot_of_one: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_ff.state == ST_ROT_STEP && s_ff.cnt == 8'h01 && s_ff.cnt_one) |=>
      (s_ff.flags[FLAG_OF] == (top_bit(s_ff.dest, s_ff.word) ^ s_ff.flags[FLAG_CF])))
    else $error("overflow after single rotate wrong");
  a_rot_flags_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_ff.busy && s_ff.op == OP_ROL) |=> ((s_ff.flags & 16'hF7FE) == ($past(s_ff.flags) & 16'hF7FE)))
    else $error("rotate changed other flags");
  a_rot_mem_back: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_ff.state == ST_ROT_STEP && s_ff.cnt == 8'h00 && s_ff.dest_mem) |=> mem_req && mem_we
      && (mem_wdata == $past(s_ff.dest)))
    else $error("memory destination not written back");

endmodule

// *** verif/return_and_rotate_left_exec_tb.sv ***
module return_and_rotate_left_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic mem_req, mem_we, mem_word, mem_ack, wr_seen;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, wr_addr, wr_data, sp, fl, v, x;
  logic [31:0] rv, e;
  logic [7:0] n, imm;
  logic [16:0] rd_q[$];
  logic [1:0] dly;
  int err_total, compares, seed, k;
  return_and_rotate_left_exec u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_we(mem_we),
    .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  // Clock at 250 MHz
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Stack contents as seen by the bench
  function automatic logic [15:0] mem_fn(logic [15:0] a);
    return ~a ^ 16'h3C5A;
  endfunction
  // Expected flags and destination after a left rotate
  function automatic logic [31:0] rol_exp(logic [15:0] d, logic [7:0] c, logic w, logic [15:0] f);
    logic cy;
    cy = f[FLAG_CF];
    for (int i = 0; i < c; i++) begin
      cy = w ? d[15] : d[7];
      if (w) d = {d[14:0], cy};
      else d[7:0] = {d[6:0], cy};
    end
    if (c != 8'h00) f[FLAG_CF] = cy;
    if (c == 8'h01) f[FLAG_OF] = (w ? d[15] : d[7]) ^ cy;
    return {f, d};
  endfunction
  // Memory side: acks after a random delay, rdata scrambled outside the ack
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (dly == 2'h0) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem_fn(mem_addr);
        dly <= 2'($random(seed));
        if (mem_we) begin
          wr_seen <= 1'b1;
          wr_addr <= mem_addr;
          wr_data <= mem_wdata;
        end else rd_q.push_back({mem_word, mem_addr});
      end else dly <= dly - 2'h1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    axi_write(a, {16'h0000, d}, resp);
    check(resp, RESP_OKAY, "write response");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
    axi_read(a, rv, resp);
    check({resp, rv[15:0]}, {RESP_OKAY, exp}, what);
  endtask
  // Starts one operation and polls for done
  task automatic run_op(input logic [7:0] ctrl);
    int t;
    wr(OFS_CTRL, {8'h00, ctrl});
    t = 0;
    do begin
      axi_read(OFS_STATUS, rv, resp);
      t++;
    end while (rv[STAT_DONE] !== 1'b1 && t < 200);
    check(rv[STAT_DONE], 1'b1, "operation done");
  endtask
  // Watchdog
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
  initial begin
    seed = 17785;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, mem_ack, wr_seen, dly} = '0;
    {mem_rdata, wr_addr, wr_data} = '0;
    s_axi_wstrb = 4'hF;
    err_total = 0;
    compares = 0;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(posedge aclk);
    check({s_axi_awready, s_axi_wready, s_axi_arready, mem_req}, 4'hE, "ready after reset");
    rd_chk(OFS_SP, RST_WORD, "stack pointer reset");
    axi_read(8'h40, rv, resp);
    check(resp, RESP_SLVERR, "unmapped read");
    axi_write(8'h48, 32'h0000_1234, resp);
    check(resp, RESP_SLVERR, "unmapped write");
    // Near and far returns, with and without pop value
    for (k = 0; k < 8; k++) begin
      sp = 16'($random(seed)) & 16'hFFFE;
      imm = 8'($random(seed)) & 8'h7E;
      fl = 16'($random(seed)) & 16'h0FD5;
      wr(OFS_SP, sp);
      wr(OFS_FLAGS, fl);
      wr(OFS_IMM, {8'h00, imm});
      rd_q.delete();
      run_op({4'h0, k[1], (k[0] ? OP_RET_FAR : OP_RET_NEAR), 1'b1});
      rd_chk(OFS_IP, mem_fn(sp), "instruction pointer");
      check(rd_q[0], {1'b1, sp}, "first pop address");
      if (k[0]) begin
        check(rd_q[1], {1'b1, sp + STACK_STEP}, "second pop address");
        rd_chk(OFS_CS, mem_fn(sp + STACK_STEP), "code segment");
      end
      x = sp + (k[0] ? 16'h0004 : 16'h0002) + (k[1] ? {8'h00, imm} : 16'h0000);
      rd_chk(OFS_SP, x, "stack pointer after return");
      rd_chk(OFS_FLAGS, fl, "flags after return");
    end
    // Rotates on register and memory, count from immediate or count register
    for (k = 0; k < 16; k++) begin
      v = 16'($random(seed));
      fl = 16'($random(seed)) & 16'h0FD5;
      n = (k < 4) ? 8'(k[1]) : (k >= 12) ? 8'(k[0] ^ k[1]) : 8'($random(seed)) & 8'h1F;
      wr(OFS_DEST, v);
      wr(OFS_FLAGS, fl);
      wr(OFS_IMM, {8'h00, k[2] ? n + 8'h03 : n});
      wr(OFS_CL, {8'h00, k[2] ? n : n + 8'h05});
      rd_q.delete();
      wr_seen <= 1'b0;
      run_op({1'b0, k[3], k[2], k[0], 1'b0, OP_ROL, 1'b1});
      e = rol_exp(k[3] ? mem_fn(v) : v, n, k[0], fl);
      if (k[3]) begin
        check(rd_q.size(), (n != 8'h00) ? 1 : 0, "operand reads");
        check(wr_seen, n != 8'h00, "operand write back");
        if (n != 8'h00) begin
          check(rd_q[0], {k[0], v}, "operand read address");
          check({wr_seen, wr_addr}, {1'b1, v}, "operand write address");
          check(k[0] ? wr_data : {8'h00, wr_data[7:0]}, k[0] ? e[15:0] : {8'h00, e[7:0]}, "memory result");
        end
      end else rd_chk(OFS_DEST, e[15:0], "register result");
      rd_chk(OFS_FLAGS, e[31:16], "flags after rotate");
    end
    give_verdict();
  end
endmodule
